/* logic/down_timer.v */
// Purpose: Retriggerable down counter advanced by an external tick.
// Assumes: Load and clear are single-cycle strobes; clear wins over load.
// Notes:   Busy stays high from load until the count runs out.
`timescale 1ns/1ps
module down_timer (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire        tick,
   input  wire        load,
   input  wire [12:0] load_val,
   input  wire        clr,
   output wire        busy
);
   reg [12:0] cnt_r;

   assign busy = (cnt_r != 13'h0000);

   always @(posedge aclk) begin
      if (!aresetn || clr) begin
         cnt_r <= 13'h0000;
      end else if (load) begin
         cnt_r <= load_val;
      end else if (tick && busy) begin
         cnt_r <= cnt_r - 13'h0001;
      end
   end
endmodule

/* logic/sect_map.vh */
// Purpose: Register map, field positions, reset values and timing counts
//          for the sectionalizer count-and-trip logic.
// Assumes: 25 MHz aclk; AXI4-Lite byte addresses.
// Notes:   Seconds-based times are kept in tenths of a second.
`ifndef SECT_MAP_VH
`define SECT_MAP_VH

// Register byte offsets
`define OFS_CTRL        4'h0
`define OFS_PH_THR      4'h4
`define OFS_GND_THR     4'h8
`define OFS_STATUS      4'hc
`define OFS_CMD         4'h0
`define OFS_CMD_ADDR    5'h10

// Control register fields
`define CTRL_CTO_LSB    0
`define CTRL_MUL_LSB    2
`define CTRL_PW_LSB     5
`define CTRL_GB_LSB     7
`define CTRL_RESET      10'h001

// Threshold reset values (amps)
`define PH_THR_RESET    12'h050
`define GND_THR_RESET   12'h028

// Status bit positions
`define ST_TRIP         2
`define ST_PH_RESTR     3
`define ST_GND_BLK      4
`define ST_FAULT_INT    5

// Command bits
`define CMD_CLR_TRIP    0

// Inrush multiplier selections
`define MUL_X1          3'h0
`define MUL_X2          3'h1
`define MUL_X4          3'h2
`define MUL_X6          3'h3
`define MUL_X8          3'h4

// Timebase: one tick per tenth of a second
`define CLK_NS          40
`define TICK_NS         100000000
`define TICK_CYC        (`TICK_NS / `CLK_NS)

// Times in tenths of a second
`define MEM_TENTHS      13'd600
`define RESET_TENTHS    13'd4500
`define GB_0P3          13'd3
`define GB_0P7          13'd7
`define GB_1P5          13'd15
`define GB_3P0          13'd30
`define GB_5P0          13'd50

// Phase restraint windows in line cycles
`define PW_5            13'd5
`define PW_10           13'd10
`define PW_15           13'd15
`define PW_20           13'd20

`endif

/* logic/sectionalizer_count_trip_logic.v */
// Purpose: Count-and-trip control of a three-phase line sectionalizer.
// Assumes: Magnitude inputs are synchronous amp codes from the sensing
//          front end; line_cycle is a one-cycle pulse per line cycle.
// Notes:   Settings reach the block over AXI4-Lite.
//
// Summary of operation
// - Compare three phase and one ground channel against their own thresholds.
// - Count only when an overcurrent flowed and then current fell to zero.
// - Hold at most three counts; further interruptions add nothing.
// - Trip once the count equals the counts-to-open setting of one to three.
// - While tripping, enable discharge of stored energy through the tripper coil.
// - Each count lives 60 seconds; trip needs all counts within that span.
// - Clear unfinished counts completely within 7-1/2 minutes.
// - No count when at least 3-1/2 amps of load keeps flowing after fault.
// - Overcurrent seen at interruption means reclose overcurrent is fault.
// - Otherwise raise phase threshold by 2, 4, 6 or 8, or block it.
// - Phase restraint lasts 5, 10, 15 or 20 cycles after restoration.
// - In inrush case block ground detection 0.3 to 5 seconds after restoration.
// - Multiplier also offers unity and block choices.
//
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "sect_map.vh"
module sectionalizer_count_trip_logic #(
   parameter TICK_CYC = `TICK_CYC
) (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [11:0] ph_mag_a,
   input  wire [11:0] ph_mag_b,
   input  wire [11:0] ph_mag_c,
   input  wire [11:0] gnd_mag,
   input  wire        load_present,
   input  wire        line_cycle,
   output reg         trip_cmd_r,
   output reg         discharge_en_r,
   input  wire [31:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [31:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready
);
   ////////////////////////////////////////////////////////////////////////
   // Functions
   function [15:0] scale_thr;
      input [11:0] thr;
      input [2:0]  sel;
      begin
         case (sel)
            `MUL_X1: scale_thr = {4'h0, thr};
            `MUL_X2: scale_thr = {3'h0, thr, 1'b0};
            `MUL_X4: scale_thr = {2'h0, thr, 2'h0};
            `MUL_X6: scale_thr = {2'h0, thr, 2'h0} + {3'h0, thr, 1'b0};
            `MUL_X8: scale_thr = {1'b0, thr, 3'h0};
            default: scale_thr = 16'hffff;
         endcase
      end
   endfunction

   function [12:0] pw_cycles;
      input [1:0] sel;
      begin
         case (sel)
            2'h0:    pw_cycles = `PW_5;
            2'h1:    pw_cycles = `PW_10;
            2'h2:    pw_cycles = `PW_15;
            default: pw_cycles = `PW_20;
         endcase
      end
   endfunction

   function [12:0] gb_tenths;
      input [2:0] sel;
      begin
         case (sel)
            3'h0:    gb_tenths = `GB_0P3;
            3'h1:    gb_tenths = `GB_0P7;
            3'h2:    gb_tenths = `GB_1P5;
            3'h3:    gb_tenths = `GB_3P0;
            default: gb_tenths = `GB_5P0;
         endcase
      end
   endfunction

   function [31:0] wmask;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  st;
      integer      i;
      begin
         wmask = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (st[i]) begin
               wmask[i*8 +: 8] = nw[i*8 +: 8];
            end
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Settings and state
   reg  [9:0]  ctrl_r;
   reg  [11:0] ph_thr_r;
   reg  [11:0] gnd_thr_r;
   reg         load_prev_r;
   reg         oc_seen_r;
   reg         fault_int_r;
   reg  [22:0] tick_cnt_r;
   reg         tick_r;
   reg  [1:0]  count_r;
   reg         ph_restr_r;
   reg         gnd_blk_r;

   wire [1:0]  cto     = ctrl_r[`CTRL_CTO_LSB +: 2];
   wire [1:0]  cto_eff = (cto == 2'h0) ? 2'h1 : cto;
   wire [2:0]  mul_sel = ctrl_r[`CTRL_MUL_LSB +: 3];
   wire [1:0]  pw_sel  = ctrl_r[`CTRL_PW_LSB +: 2];
   wire [2:0]  gb_sel  = ctrl_r[`CTRL_GB_LSB +: 3];

   wire [2:0]  slot_busy;
   wire        rst_busy;
   wire        pw_busy;
   wire        gb_busy;

   ////////////////////////////////////////////////////////////////////////
   // Overcurrent detection
   // Load above the restraint level counts as current flowing
   wire        int_evt  = load_prev_r && !load_present;
   wire        rest_evt = !load_prev_r && load_present;
   wire        inrush   = rest_evt && !fault_int_r;

   // Restraint also covers the restoring edge, before its flag is set
   wire [15:0] ph_eff = (ph_restr_r || inrush) ? scale_thr(ph_thr_r, mul_sel)
                                               : {4'h0, ph_thr_r};
   wire        ph_oc  = ({4'h0, ph_mag_a} >= ph_eff) ||
                        ({4'h0, ph_mag_b} >= ph_eff) ||
                        ({4'h0, ph_mag_c} >= ph_eff);
   wire        gnd_oc = (gnd_thr_r != 12'h000) && !gnd_blk_r && !inrush &&
                        (gnd_mag >= gnd_thr_r);
   wire        any_oc = ph_oc || gnd_oc;

   ////////////////////////////////////////////////////////////////////////
   // Count generation
   // A count only forms when current truly drops out; while load stays
   // above the restraint level the fault was cleared further down.
   wire        cnt_evt  = int_evt && oc_seen_r && !trip_cmd_r;
   wire [2:0]  slot_ld;
   assign slot_ld[0] = cnt_evt && !slot_busy[0];
   assign slot_ld[1] = cnt_evt && slot_busy[0] && !slot_busy[1];
   assign slot_ld[2] = cnt_evt && slot_busy[0] && slot_busy[1] &&
                       !slot_busy[2];

   wire [1:0]  live_cnt = {1'b0, slot_busy[0]} + {1'b0, slot_busy[1]} +
                          {1'b0, slot_busy[2]};
   wire        trip_set = (live_cnt >= cto_eff);
   wire        cnt_clr  = (rst_busy == 1'b0) && (live_cnt != 2'h0);
   wire        slot_clr = trip_set || cnt_clr;

   ////////////////////////////////////////////////////////////////////////
   // Timers
   down_timer u_slot0 (.aclk(aclk), .aresetn(aresetn), .tick(tick_r), .load(slot_ld[0]),
      .load_val(`MEM_TENTHS), .clr(slot_clr), .busy(slot_busy[0]));
   down_timer u_slot1 (.aclk(aclk), .aresetn(aresetn), .tick(tick_r), .load(slot_ld[1]),
      .load_val(`MEM_TENTHS), .clr(slot_clr), .busy(slot_busy[1]));
   down_timer u_slot2 (.aclk(aclk), .aresetn(aresetn), .tick(tick_r), .load(slot_ld[2]),
      .load_val(`MEM_TENTHS), .clr(slot_clr), .busy(slot_busy[2]));
   // Backstop: first count of a sequence starts the full reset span
   down_timer u_reset (.aclk(aclk), .aresetn(aresetn), .tick(tick_r),
      .load(cnt_evt && (live_cnt == 2'h0)), .load_val(`RESET_TENTHS), .clr(trip_set),
      .busy(rst_busy));
   down_timer u_phwin (.aclk(aclk), .aresetn(aresetn), .tick(line_cycle), .load(inrush),
      .load_val(pw_cycles(pw_sel)), .clr(int_evt), .busy(pw_busy));
   down_timer u_gndblk (.aclk(aclk), .aresetn(aresetn), .tick(tick_r), .load(inrush),
      .load_val(gb_tenths(gb_sel)), .clr(int_evt), .busy(gb_busy));

   ////////////////////////////////////////////////////////////////////////
   // Core sequencing
   always @(posedge aclk) begin
      if (!aresetn) begin
         tick_cnt_r  <= 23'h000000;
         tick_r      <= 1'b0;
         load_prev_r <= 1'b0;
         oc_seen_r   <= 1'b0;
         fault_int_r <= 1'b0;
         count_r     <= 2'h0;
         ph_restr_r  <= 1'b0;
         gnd_blk_r   <= 1'b0;
      end else begin
         // Fixed timebase from aclk
         if ({9'h000, tick_cnt_r} == TICK_CYC - 1) begin
            tick_cnt_r <= 23'h000000;
            tick_r     <= 1'b1;
         end else begin
            tick_cnt_r <= tick_cnt_r + 23'h000001;
            tick_r     <= 1'b0;
         end
         load_prev_r <= load_present;
         if (int_evt) begin
            fault_int_r <= oc_seen_r;
            oc_seen_r   <= 1'b0;
         end else if (any_oc && load_present) begin
            oc_seen_r <= 1'b1;
         end else if (load_present) begin
            // Fault gone while load still flows: cleared further down the line
            oc_seen_r <= 1'b0;
         end
         count_r    <= live_cnt;
         // Restraint applies from the restoring edge itself
         ph_restr_r <= pw_busy || inrush;
         gnd_blk_r  <= gb_busy || inrush;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Trip output; a new trip wins over a software clear
   wire clr_trip;

   always @(posedge aclk) begin
      if (!aresetn) begin
         trip_cmd_r     <= 1'b0;
         discharge_en_r <= 1'b0;
      end else begin
         if (trip_set) begin
            trip_cmd_r <= 1'b1;
         end else if (clr_trip) begin
            trip_cmd_r <= 1'b0;
         end
         discharge_en_r <= trip_set || (trip_cmd_r && !clr_trip);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave
   reg         aw_have_r;
   reg         w_have_r;
   reg  [4:0]  waddr_r;
   reg  [31:0] wdata_r;
   reg  [3:0]  wstrb_r;
   wire        do_wr = aw_have_r && w_have_r && !s_axi_bvalid;
   wire        wr_ok = (waddr_r[4] == 1'b0) || (waddr_r == `OFS_CMD_ADDR);
   wire [31:0] ctrl_wm = wmask({22'h0, ctrl_r}, wdata_r, wstrb_r);
   wire [31:0] ph_wm   = wmask({20'h0, ph_thr_r}, wdata_r, wstrb_r);
   wire [31:0] gnd_wm  = wmask({20'h0, gnd_thr_r}, wdata_r, wstrb_r);

   assign clr_trip = do_wr && (waddr_r == `OFS_CMD_ADDR) &&
                     wstrb_r[0] && wdata_r[`CMD_CLR_TRIP];

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'h0;
         aw_have_r     <= 1'b0;
         w_have_r      <= 1'b0;
         waddr_r       <= 5'h00;
         wdata_r       <= 32'h00000000;
         wstrb_r       <= 4'h0;
         ctrl_r        <= `CTRL_RESET;
         ph_thr_r      <= `PH_THR_RESET;
         gnd_thr_r     <= `GND_THR_RESET;
      end else begin
         s_axi_awready <= s_axi_awvalid && !aw_have_r && !s_axi_awready;
         s_axi_wready  <= s_axi_wvalid && !w_have_r && !s_axi_wready;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            waddr_r   <= s_axi_awaddr[4:0];
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
         end
         if (do_wr) begin
            aw_have_r    <= 1'b0;
            w_have_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
            if (waddr_r[4:2] == `OFS_CTRL >> 2) begin
               ctrl_r <= ctrl_wm[9:0];
            end
            if (waddr_r[4:2] == `OFS_PH_THR >> 2) begin
               ph_thr_r <= ph_wm[11:0];
            end
            if (waddr_r[4:2] == `OFS_GND_THR >> 2) begin
               gnd_thr_r <= gnd_wm[11:0];
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   reg [31:0] rd_val;
   reg        rd_ok;

   always @* begin
      rd_val = 32'h00000000;
      rd_ok  = 1'b1;
      case (s_axi_araddr[4:2])
         3'h0:    rd_val = {22'h0, ctrl_r};
         3'h1:    rd_val = {20'h0, ph_thr_r};
         3'h2:    rd_val = {20'h0, gnd_thr_r};
         3'h3:    rd_val = {26'h0, fault_int_r, gnd_blk_r, ph_restr_r,
                            trip_cmd_r, count_r};
         3'h4:    rd_val = 32'h00000000;
         default: rd_ok  = 1'b0;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= 2'h0;
      end else begin
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_val;
            s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule

/* tb/sect_trip_asserts.sv */
// Purpose: Port checks for the sectionalizer count-and-trip block.
// Assumes: One write and one read in flight at a time.
// Notes:   Trip rise is tied to the dead-line interval; trip fall is tied to a write response.
`timescale 1ns/1ps
module sect_trip_asserts (
   input wire        aclk,
   input wire        aresetn,
   input wire        load_present,
   input wire        trip_cmd_r,
   input wire        discharge_en_r,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire [31:0] s_axi_araddr,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0]  s_axi_rresp,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_discharge_follows: assert property (discharge_en_r == trip_cmd_r)
      else $error("discharge enable differs from trip");
   // A count only forms once the line has gone dead
   a_trip_dead_line: assert property ($rose(trip_cmd_r) |->
      !$past(load_present) && !$past(load_present, 2))
      else $error("trip rose with current flowing");
   a_trip_latched: assert property ($fell(trip_cmd_r) |-> s_axi_bvalid)
      else $error("trip dropped without a write");
   a_aw_ready: assert property (s_axi_awvalid && !s_axi_awready && !s_axi_bvalid
      |-> ##[1:2] s_axi_awready)
      else $error("write address not accepted");
   a_b_after_aw: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:3] s_axi_bvalid)
      else $error("write response missing");
   a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response not released");
   a_ar_ready: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
      |-> ##[1:2] s_axi_arready)
      else $error("read address not accepted");
   a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   a_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read data not released");
   a_slverr_read: assert property (s_axi_arvalid && s_axi_arready
      && s_axi_araddr[4:0] >= 5'h14 |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");

   c_trip: cover property ($rose(trip_cmd_r));
   c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
   c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule

////////////////////////////////////////////////////////////////
bind sectionalizer_count_trip_logic sect_trip_asserts u_chk (
   .aclk(aclk), .aresetn(aresetn), .load_present(load_present),
   .trip_cmd_r(trip_cmd_r), .discharge_en_r(discharge_en_r),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);

/* tb/sectionalizer_count_trip_logic_bench.sv */
// Purpose: Self-checking bench for the sectionalizer count-and-trip block.
// Assumes: Tick of 10 clocks per tenth of a second, 20-clock line cycle.
// Notes:   Every scenario leaves the trip cleared for the next one.
`timescale 1ns/1ps
module sectionalizer_count_trip_logic_bench;
   localparam TK = 10;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [11:0] ph_amp = 12'h000;
   logic [1:0]  ph_sel = 2'd0;
   logic [11:0] gnd_amp = 12'h000;
   logic        load_on = 1'b0;
   logic [11:0] ph_mag_a, ph_mag_b, ph_mag_c, gnd_mag;
   logic        load_present, line_cycle, trip_cmd_r, discharge_en_r;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   logic [31:0] s_axi_rdata, rdv;
   int          n_errors = 0;
   int          total_checks = 0;

   initial forever #20 aclk = ~aclk;

   sense_model far (.aclk(aclk), .ph_amp(ph_amp), .ph_sel(ph_sel), .gnd_amp(gnd_amp),
      .load_on(load_on), .ph_mag_a(ph_mag_a), .ph_mag_b(ph_mag_b), .ph_mag_c(ph_mag_c),
      .gnd_mag(gnd_mag), .load_present(load_present), .line_cycle(line_cycle));

   sectionalizer_count_trip_logic #(.TICK_CYC(TK)) dut (.aclk(aclk), .aresetn(aresetn),
      .ph_mag_a(ph_mag_a), .ph_mag_b(ph_mag_b), .ph_mag_c(ph_mag_c), .gnd_mag(gnd_mag),
      .load_present(load_present), .line_cycle(line_cycle), .trip_cmd_r(trip_cmd_r),
      .discharge_en_r(discharge_en_r), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready));

   ////////////////////////////////////////////////////////////////
   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Address and data go out together; each is dropped once taken
   task wr(input logic [31:0] a, input logic [31:0] d);
      int n;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && n < 50);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n >= 50) chk(32'h1, 32'h0);
      @(posedge aclk);
   endtask

   task rd(input logic [31:0] a);
      int n;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && n < 50);
      rdv = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n >= 50) chk(32'h1, 32'h0);
      @(posedge aclk);
   endtask

   // Current flows for hold clocks, then the backup device opens the line
   task pulse(input logic [11:0] p, input logic [1:0] s, input logic [11:0] g, input int hold);
      ph_amp <= p;
      ph_sel <= s;
      gnd_amp <= g;
      load_on <= 1'b1;
      repeat (hold) @(posedge aclk);
      load_on <= 1'b0;
      repeat (12) @(posedge aclk);
   endtask

   task trip_is(input logic e);
      chk({31'h0, trip_cmd_r}, {31'h0, e});
      chk({31'h0, discharge_en_r}, {31'h0, e});
      if (trip_cmd_r === 1'b1) begin
         wr(32'h10, 32'h1);
         chk({31'h0, trip_cmd_r}, 32'h0);
      end
   endtask

   // Idle interruption first, so the next restoration is treated as inrush
   task inr(input logic [31:0] c, input logic [11:0] p, input logic [11:0] g,
            input int hold, input logic e);
      wr(32'h0, c);
      pulse(12'h000, 2'd0, 12'h000, 20);
      pulse(p, 2'd0, g, hold);
      trip_is(e);
   endtask

   ////////////////////////////////////////////////////////////////
   task t_regs;
      rd(32'h0);
      chk(rdv, 32'h1);
      rd(32'h4);
      chk(rdv, 32'h50);
      rd(32'h8);
      chk(rdv, 32'h28);
      wr(32'h4, 32'h123);
      rd(32'h4);
      chk(rdv, 32'h123);
      wr(32'h4, 32'h50);
      rd(32'h10);
      chk(rdv, 32'h0);
      rd(32'h14);
      chk({30'h0, rsp}, 32'h2);
      chk(rdv, 32'h0);
      wr(32'h18, 32'h5);
      chk({30'h0, rsp}, 32'h2);
   endtask

   task t_phase;
      for (int s = 0; s < 3; s++) begin
         pulse((s == 2) ? 12'h050 : 12'h060, s[1:0], 12'h000, 20);
         trip_is(1'b1);
      end
      pulse(12'h000, 2'd0, 12'h030, 20);
      trip_is(1'b1);
      pulse(12'h04f, 2'd1, 12'h000, 20);
      trip_is(1'b0);
   endtask

   task t_restrain;
      ph_amp <= 12'h060;
      load_on <= 1'b1;
      repeat (20) @(posedge aclk);
      ph_amp <= 12'h000;
      repeat (20) @(posedge aclk);
      load_on <= 1'b0;
      repeat (12) @(posedge aclk);
      trip_is(1'b0);
   endtask

   task t_count3;
      wr(32'h0, 32'h013);
      pulse(12'h060, 2'd0, 12'h000, 150);
      trip_is(1'b0);
      pulse(12'h060, 2'd0, 12'h000, 20);
      rd(32'hc);
      chk(rdv, 32'h22);
      pulse(12'h060, 2'd0, 12'h000, 20);
      trip_is(1'b1);
   endtask

   task t_memory;
      wr(32'h0, 32'h002);
      pulse(12'h060, 2'd0, 12'h000, 20);
      repeat (6100) @(posedge aclk);
      pulse(12'h060, 2'd0, 12'h000, 20);
      trip_is(1'b0);
      pulse(12'h060, 2'd0, 12'h000, 20);
      trip_is(1'b1);
   endtask

   task t_inrush;
      int k;
      for (int d = 0; d < 2; d++)
         for (int m = 0; m < 6; m++) begin
            k = (m == 0) ? 1 : (m == 5) ? 0 : 2 * m;
            inr(32'h1 | (m << 2), k ? 12'(80 * k - 1 + d) : 12'hfff, 12'h000, 40,
                k != 0 && d == 1);
         end
      inr(32'h071, 12'h060, 12'h000, 300, 1'b0);
      inr(32'h011, 12'h060, 12'h000, 140, 1'b1);
      inr(32'h001, 12'h000, 12'h030, 15, 1'b0);
      inr(32'h001, 12'h000, 12'h030, 60, 1'b1);
      inr(32'h201, 12'h000, 12'h030, 400, 1'b0);
      inr(32'h201, 12'h000, 12'h030, 600, 1'b1);
   endtask

   task stop_test;
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_regs;
      $display("register test ended");
      t_phase;
      $display("phase and ground test ended");
      t_restrain;
      $display("count restraint test ended");
      t_count3;
      $display("three count test ended");
      t_memory;
      $display("count memory test ended");
      t_inrush;
      $display("inrush test ended");
      stop_test;
   end

   // Whole run needs about 9600 clocks
   initial begin
      repeat (40000) @(posedge aclk);
      n_errors++;
      $display("ERROR t=%0t run hung", $time);
      stop_test;
   end
endmodule

/* tb/sense_model.sv */
// Purpose: Far-side model: phase, ground and load sensing feeding the block.
// Assumes: Bench sets amps and load; the line frequency runs free.
// Notes:   A dead line reads zero on every channel, as real current does.
`timescale 1ns/1ps
module sense_model #(
   parameter LC_CYC = 20
) (
   input  wire        aclk,
   input  wire [11:0] ph_amp,
   input  wire [1:0]  ph_sel,
   input  wire [11:0] gnd_amp,
   input  wire        load_on,
   output reg  [11:0] ph_mag_a = 12'h000,
   output reg  [11:0] ph_mag_b = 12'h000,
   output reg  [11:0] ph_mag_c = 12'h000,
   output reg  [11:0] gnd_mag = 12'h000,
   output reg         load_present = 1'b0,
   output reg         line_cycle = 1'b0
);
   integer lc_cnt = 0;

   // Line cycles keep coming whether or not current flows
   always @(posedge aclk) begin
      lc_cnt <= (lc_cnt >= LC_CYC - 1) ? 0 : lc_cnt + 1;
      line_cycle <= (lc_cnt == 0);
      load_present <= load_on;
      ph_mag_a <= (load_on && ph_sel == 2'd0) ? ph_amp : 12'h000;
      ph_mag_b <= (load_on && ph_sel == 2'd1) ? ph_amp : 12'h000;
      ph_mag_c <= (load_on && ph_sel == 2'd2) ? ph_amp : 12'h000;
      gnd_mag <= load_on ? gnd_amp : 12'h000;
   end
endmodule
